// ---- design/mcs_clock_sync.sv ----
// multichip clock generator, sync generator and sync receiver
`timescale 1ns/1ns
`include "mcs_defines.svh"
module mcs_clock_sync #(
    parameter int RATE_W   = `MCS_RATE_W,
    parameter int PRESET_W = `MCS_PRESET_W,
    parameter int DELAY_W  = `MCS_DELAY_W
) (
    input  wire logic                 mclk,
    input  wire logic                 srst,
    input  wire logic [1:0]           mode_sel,
    input  wire logic                 serial_iface_sel,
    input  wire logic [RATE_W-1:0]    cic_rate,
    input  wire logic                 update_strobe,
    input  wire logic                 sync_gen_enable,
    input  wire logic                 sync_polarity,
    input  wire logic [DELAY_W-1:0]   sync_out_delay,
    input  wire logic                 sync_rx_enable,
    input  wire logic                 sync_in,
    input  wire logic [PRESET_W-1:0]  sync_preset,
    output logic                      sync_out_p_ff,
    output logic                      sync_out_n_ff,
    output logic                      sync_out_fall_ff,
    output logic [DELAY_W-1:0]        sync_out_delay_ff,
    output logic                      sync_clk_ff,
    output logic                      tree2_clk_ff,
    output logic                      tree3_clk_ff,
    output logic [`MCS_COMMON_W-1:0]  common_cnt_ff,
    output logic [RATE_W-1:0]         r_cnt_ff,
    output logic                      sync_pulse_ff,
    output logic [1:0]                act_mode_ff,
    output logic                      act_serial_ff,
    output logic [RATE_W-1:0]         act_rate_ff
);
    // elaboration check on widths the logic can serve
    if (RATE_W < 2 || RATE_W > 6 || PRESET_W != RATE_W || DELAY_W < 1) begin : g_chk
        $error("mcs_clock_sync: unsupported parameter widths");
    end

    ////////////////////////////////////////////////////////////////////////////
    // update strobe and active settings

    logic                 strobe_d_ff;
    logic                 strobe_rise;
    logic                 tree2_on;
    logic                 tree3_on;
    logic                 use_rate;
    logic [RATE_W-1:0]    rate_eff;
    logic [RATE_W-1:0]    nxt_preset;

    assign strobe_rise = update_strobe && !strobe_d_ff;

    // edge memory for the update strobe
    always_ff @(posedge mclk) begin
        if (srst) begin
            strobe_d_ff <= 1'b0;
        end else begin
            strobe_d_ff <= update_strobe;
        end
    end

    // buffered inputs become active only on a strobe rising edge
    always_ff @(posedge mclk) begin
        if (srst) begin
            act_mode_ff   <= mcs_pkg::MCS_MODE_TONE;
            act_serial_ff <= 1'b0;
            act_rate_ff   <= RATE_W'(`MCS_RST_RATE);
        end else if (strobe_rise) begin
            act_mode_ff   <= mode_sel;
            act_serial_ff <= serial_iface_sel;
            act_rate_ff   <= cic_rate;
        end
    end

    // tree enables and effective rate; a rate of zero acts as one
    always_comb begin
        tree2_on = (act_mode_ff == mcs_pkg::MCS_MODE_IDAC)
                || (act_mode_ff == mcs_pkg::MCS_MODE_QUADRATURE_UPCONVERSION_MODE && !act_serial_ff);
        tree3_on = (act_mode_ff == mcs_pkg::MCS_MODE_QUADRATURE_UPCONVERSION_MODE && act_serial_ff);
        rate_eff = (act_rate_ff == '0) ? RATE_W'(`MCS_RATE_ONE) : act_rate_ff;
        use_rate = (tree2_on || tree3_on) && (rate_eff != RATE_W'(`MCS_RATE_ONE));
    end

    ////////////////////////////////////////////////////////////////////////////
    // sync receiver

    logic sync_in_d_ff;

    // sample the delayed sync input on the rising system clock
    always_ff @(posedge mclk) begin
        if (srst) begin
            sync_in_d_ff <= 1'b0;
        end else begin
            sync_in_d_ff <= sync_in;
        end
    end

    // one-cycle pulse per rising sync input edge while sync_rx_enable is high
    always_ff @(posedge mclk) begin
        if (srst) begin
            sync_pulse_ff <= 1'b0;
        end else begin
            sync_pulse_ff <= sync_rx_enable && sync_in && !sync_in_d_ff;
        end
    end

    // preset clamp: raised to 2, then capped at the rate, so a rate of one gives 1
    always_comb begin
        nxt_preset = sync_preset;
        if (nxt_preset < PRESET_W'(`MCS_PRESET_MIN)) begin
            nxt_preset = PRESET_W'(`MCS_PRESET_MIN);
        end
        if (nxt_preset > rate_eff) begin
            nxt_preset = rate_eff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // clock generator

    logic t3_half_ff;

    // common tree counts every cycle; sync pulse presets it
    always_ff @(posedge mclk) begin
        if (srst) begin
            common_cnt_ff <= `MCS_COMMON_INIT;
        end else if (sync_pulse_ff) begin
            common_cnt_ff <= `MCS_COMMON_INIT;
        end else begin
            common_cnt_ff <= common_cnt_ff + `MCS_COMMON_W'(1);
        end
    end

    // presettable R downcounter, steps once per common period
    always_ff @(posedge mclk) begin
        if (srst) begin
            r_cnt_ff <= RATE_W'(`MCS_RST_RATE);
        end else if (sync_pulse_ff) begin
            r_cnt_ff <= nxt_preset;
        end else if (common_cnt_ff == `MCS_COMMON_LAST) begin
            if (r_cnt_ff <= RATE_W'(`MCS_RATE_ONE)) begin
                r_cnt_ff <= rate_eff;
            end else begin
                r_cnt_ff <= r_cnt_ff - RATE_W'(1);
            end
        end
    end

    // tree clocks: common tree MSB out at one sixteenth rate, second and third trees from R divider
    always_ff @(posedge mclk) begin
        if (srst || sync_pulse_ff) begin
            sync_clk_ff  <= 1'b0;
            tree2_clk_ff <= 1'b0;
            tree3_clk_ff <= 1'b0;
            t3_half_ff   <= 1'b0;
        end else begin
            sync_clk_ff <= common_cnt_ff[`MCS_COMMON_W-1];
            if (!tree2_on) begin
                tree2_clk_ff <= 1'b0;
            end else if (common_cnt_ff[0]) begin
                tree2_clk_ff <= (r_cnt_ff == RATE_W'(`MCS_RATE_ONE));
            end
            if (!tree3_on) begin
                tree3_clk_ff <= 1'b0;
                t3_half_ff   <= 1'b0;
            end else if (common_cnt_ff == `MCS_COMMON_LAST
                         && r_cnt_ff <= RATE_W'(`MCS_RATE_ONE)) begin
                t3_half_ff   <= ~t3_half_ff;
                tree3_clk_ff <= ~t3_half_ff;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sync generator

    mcs_sync_gen #(
        .RATE_W    (RATE_W)
    ) u_gen (
        .mclk      (mclk),
        .srst      (srst),
        .enable    (sync_gen_enable),
        .use_rate  (use_rate),
        .rate      (rate_eff),
        .sync_p_ff (sync_out_p_ff),
        .sync_n_ff (sync_out_n_ff)
    );

    // edge select and delay code for the output stage, about 150 ps per code
    always_ff @(posedge mclk) begin
        if (srst) begin
            sync_out_fall_ff  <= 1'b0;
            sync_out_delay_ff <= DELAY_W'(`MCS_RST_DELAY);
        end else begin
            sync_out_fall_ff  <= sync_polarity;
            sync_out_delay_ff <= sync_out_delay;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    sequence strobe_edge_s;
        !update_strobe ##1 update_strobe;
    endsequence

    sequence sync_edge_s;
        sync_rx_enable && !sync_in ##1 sync_rx_enable && sync_in;
    endsequence

    settings_load_a: assert property (strobe_edge_s |=> act_rate_ff == $past(cic_rate))
        else $error("active rate not loaded on strobe edge");
    settings_hold_a: assert property (!strobe_rise |=> $stable(act_mode_ff))
        else $error("active mode changed without strobe edge");
    sync_pulse_gen_a: assert property (sync_edge_s |=> sync_pulse_ff ##1 !sync_pulse_ff)
        else $error("sync pulse not one cycle after input edge");
    common_preset_a: assert property (sync_pulse_ff |=> common_cnt_ff == `MCS_COMMON_INIT)
        else $error("common tree not preset by sync pulse");
    preset_clamp_a: assert property (sync_pulse_ff |=> r_cnt_ff >= RATE_W'(1)
        && r_cnt_ff <= rate_eff && (r_cnt_ff >= RATE_W'(2) || rate_eff < RATE_W'(2)))
        else $error("preset out of clamp range");
    common_step_a: assert property (!sync_pulse_ff |=>
        common_cnt_ff == $past(common_cnt_ff) + `MCS_COMMON_W'(1))
        else $error("common tree did not step");
    gen_off_low_a: assert property (!sync_gen_enable |=> !sync_out_p_ff && sync_out_n_ff)
        else $error("sync out not low while disabled");
    gen_diff_a: assert property (sync_out_p_ff != sync_out_n_ff)
        else $error("sync out legs not complementary");
    // a disable in mid-level legally cuts the square wave short
    gen_base_half_a: assert property (disable iff (srst || !sync_gen_enable)
        sync_gen_enable && !use_rate && $rose(sync_out_p_ff)
        && $stable(use_rate) |-> (sync_out_p_ff && !use_rate)[*8] ##1 !sync_out_p_ff
        or (use_rate || !sync_gen_enable))
        else $error("divide by 16 half period wrong");
    tree3_off_a: assert property (!tree3_on |=> !tree3_clk_ff)
        else $error("third tree ran outside serial upconversion");
    tree2_off_a: assert property (!tree2_on |=> !tree2_clk_ff)
        else $error("second tree ran outside its modes");
endmodule // mcs_clock_sync

// ---- design/mcs_defines.svh ----
// named constants for the multichip clock sync generator
`ifndef MCS_DEFINES_SVH
`define MCS_DEFINES_SVH

`define MCS_MODE_W          2
`define MCS_RATE_W          6
`define MCS_PRESET_W        6
`define MCS_DELAY_W         5
`define MCS_COMMON_W        4
`define MCS_HALF_W          11
`define MCS_HALF_BASE       11'h008
`define MCS_HALF_PER_R      11'h010
`define MCS_PRESET_MIN      6'h02
`define MCS_RATE_ONE        6'h01
`define MCS_COMMON_LAST     4'hf
`define MCS_COMMON_INIT     4'h0
`define MCS_RST_RATE        6'h01
`define MCS_RST_DELAY       5'h00
`define MCS_STEP_PS         150

`endif

// ---- design/mcs_pkg.sv ----
// types shared by the multichip clock sync generator
package mcs_pkg;
    typedef enum logic [1:0] {
        MCS_MODE_TONE = 2'b00,
        MCS_MODE_QUADRATURE_UPCONVERSION_MODE = 2'b01,
        MCS_MODE_IDAC = 2'b10
    } mcs_mode_t;
endpackage

// ---- design/mcs_sync_gen.sv ----
// sync output square-wave divider
`timescale 1ns/1ns
`include "mcs_defines.svh"
module mcs_sync_gen #(
    parameter int RATE_W = `MCS_RATE_W
) (
    input  wire logic              mclk,
    input  wire logic              srst,
    input  wire logic              enable,
    input  wire logic              use_rate,
    input  wire logic [RATE_W-1:0] rate,
    output logic                   sync_p_ff,
    output logic                   sync_n_ff
);
    logic [`MCS_HALF_W-1:0] half_cnt_ff;
    logic [`MCS_HALF_W-1:0] half_len;

    // half period: 8 cycles for divide by 16, 16*R for divide by 32R
    always_comb begin
        if (use_rate) begin
            half_len = `MCS_HALF_W'(`MCS_HALF_PER_R * rate);
        end else begin
            half_len = `MCS_HALF_BASE;
        end
    end

    // divider held in reset while disabled, toggles at each half period
    always_ff @(posedge mclk) begin
        if (srst || !enable) begin
            half_cnt_ff <= '0;
        end else if (half_cnt_ff >= half_len - `MCS_HALF_W'(1)) begin
            half_cnt_ff <= '0;
        end else begin
            half_cnt_ff <= half_cnt_ff + `MCS_HALF_W'(1);
        end
    end

    // differential 50% duty output, static low when disabled
    always_ff @(posedge mclk) begin
        if (srst || !enable) begin
            sync_p_ff <= 1'b0;
            sync_n_ff <= 1'b1;
        end else if (half_cnt_ff >= half_len - `MCS_HALF_W'(1)) begin
            sync_p_ff <= ~sync_p_ff;
            sync_n_ff <= sync_p_ff;
        end
    end
endmodule // mcs_sync_gen

// ---- verification/mcs_slave_model.sv ----
// slave-side model that times the master sync output in system clock cycles
`timescale 1ns/1ns
module mcs_slave_model (
    input  wire logic        mclk,
    input  wire logic        clr,
    input  wire logic        sync_p,
    input  wire logic        sync_n,
    output logic [15:0]      hi_len,
    output logic [15:0]      lo_len,
    output logic             diff_bad
);
    logic        last_p;
    logic [15:0] run;
    // length of each finished level; a slave locks on these edges
    always @(posedge mclk) begin
        if (clr) begin
            hi_len <= 16'h0000;
            lo_len <= 16'h0000;
            diff_bad <= 1'b0;
            run <= 16'h0000;
        end else begin
            diff_bad <= diff_bad | (sync_p === sync_n); // legs must stay complementary
            if (sync_p !== last_p) begin
                if (last_p === 1'b1) hi_len <= run;
                else lo_len <= run;
                run <= 16'h0001;
            end else begin
                run <= run + 16'h0001;
            end
        end
        last_p <= sync_p;
    end
endmodule // mcs_slave_model

// ---- verification/multichip_clock_sync_generator_tb.sv ----
// self-checking bench for the multichip clock sync generator
`timescale 1ns/1ns
`include "mcs_defines.svh"
module multichip_clock_sync_generator_tb;
    logic        mclk, srst, serial_iface_sel, update_strobe, sync_gen_enable;
    logic        sync_polarity, sync_rx_enable, sync_in, sync_out_p_ff, sync_out_n_ff;
    logic        sync_out_fall_ff, sync_clk_ff, tree2_clk_ff, tree3_clk_ff;
    logic        sync_pulse_ff, act_serial_ff, diff_bad;
    logic [1:0]  mode_sel, act_mode_ff;
    logic [5:0]  cic_rate, sync_preset, r_cnt_ff, act_rate_ff;
    logic [4:0]  sync_out_delay, sync_out_delay_ff;
    logic [3:0]  common_cnt_ff, v;
    logic [15:0] hi_len, lo_len;
    int          n_errors, total_checks, i, k;
    // generator table: mode, serial, rate, expected half period
    logic [1:0]  tm[6] = '{2'b00, 2'b11, 2'b01, 2'b01, 2'b01, 2'b10};
    logic        ts[6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
    logic [5:0]  tr[6] = '{6'h03, 6'h03, 6'h01, 6'h02, 6'h02, 6'h03};
    logic [15:0] th[6] = '{16'h0008, 16'h0008, 16'h0008, 16'h0020, 16'h0020, 16'h0030};
    // preset table against active rate 3
    logic [5:0]  pv[5] = '{6'h00, 6'h01, 6'h02, 6'h05, 6'h03};
    logic [5:0]  ex[5] = '{6'h02, 6'h02, 6'h02, 6'h03, 6'h03};

    ////////////////////////////////////////////////////////////////////////////////
    // clock, design and far-side model
    always #2 mclk = ~mclk;

    mcs_clock_sync dut (.mclk(mclk), .srst(srst), .mode_sel(mode_sel),
        .serial_iface_sel(serial_iface_sel), .cic_rate(cic_rate),
        .update_strobe(update_strobe), .sync_gen_enable(sync_gen_enable),
        .sync_polarity(sync_polarity), .sync_out_delay(sync_out_delay),
        .sync_rx_enable(sync_rx_enable), .sync_in(sync_in), .sync_preset(sync_preset),
        .sync_out_p_ff(sync_out_p_ff), .sync_out_n_ff(sync_out_n_ff),
        .sync_out_fall_ff(sync_out_fall_ff), .sync_out_delay_ff(sync_out_delay_ff),
        .sync_clk_ff(sync_clk_ff), .tree2_clk_ff(tree2_clk_ff),
        .tree3_clk_ff(tree3_clk_ff), .common_cnt_ff(common_cnt_ff), .r_cnt_ff(r_cnt_ff),
        .sync_pulse_ff(sync_pulse_ff), .act_mode_ff(act_mode_ff),
        .act_serial_ff(act_serial_ff), .act_rate_ff(act_rate_ff));

    // lengths restart while the generator is off, so no level carries over between runs
    mcs_slave_model slave (.mclk(mclk), .clr(srst || !sync_gen_enable), .sync_p(sync_out_p_ff),
        .sync_n(sync_out_n_ff), .hi_len(hi_len), .lo_len(lo_len), .diff_bad(diff_bad));

    ////////////////////////////////////////////////////////////////////////////////
    // shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask

    // buffered settings, then one strobe rise
    task automatic apply(input logic [1:0] m, input logic s, input logic [5:0] r);
        mode_sel = m;
        serial_iface_sel = s;
        cic_rate = r;
        cyc(1);
        update_strobe = 1'b1;
        cyc(1);
        update_strobe = 1'b0;
    endtask

    task automatic stop_test();
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {mclk, serial_iface_sel, update_strobe, sync_gen_enable, sync_polarity} = '0;
        {sync_rx_enable, sync_in, mode_sel, cic_rate, sync_preset, sync_out_delay} = '0;
        n_errors = 0;
        total_checks = 0;
        srst = 1'b1;
        cyc(4);
        srst = 1'b0;
        chk(sync_out_p_ff, 1'b0);
        chk(act_rate_ff, `MCS_RST_RATE);
        // common tree steps once per cycle and wraps
        v = common_cnt_ff;
        for (i = 1; i < 20; i++) begin
            cyc(1);
            chk(common_cnt_ff, 4'(v + i));
            chk(sync_clk_ff, 1'((v + i - 1) >> 3));
        end
        // strobe rise takes settings, a held strobe takes nothing more
        apply(mcs_pkg::MCS_MODE_QUADRATURE_UPCONVERSION_MODE, 1'b0, 6'h03);
        chk({act_mode_ff, act_serial_ff, act_rate_ff}, {2'b01, 1'b0, 6'h03});
        cyc(1);
        update_strobe = 1'b1;
        cyc(2);
        mode_sel = mcs_pkg::MCS_MODE_TONE;
        cyc(2);
        chk(act_mode_ff, 2'b01);
        update_strobe = 1'b0;
        sync_polarity = 1'b1;
        sync_out_delay = 5'h1f;
        cyc(1);
        chk(sync_out_fall_ff, 1'b1);
        chk(sync_out_delay_ff, 5'h1f);
        // sync output period per mode and rate, trees per mode
        for (i = 0; i < 6; i++) begin
            sync_gen_enable = 1'b0;
            apply(tm[i], ts[i], tr[i]);
            chk(sync_out_p_ff, 1'b0);
            sync_gen_enable = 1'b1;
            cyc(4 * th[i] + 4);
            chk(hi_len, th[i]);
            chk(lo_len, th[i]);
            chk(diff_bad, 1'b0);
            if (i == 0) chk(tree2_clk_ff | tree3_clk_ff, 1'b0);
            if (i == 3) chk(tree3_clk_ff, 1'b0);
            if (i == 4) chk(tree2_clk_ff, 1'b0);
            if (i >= 4) begin
                k = 0;
                while ((i == 5 ? tree2_clk_ff : tree3_clk_ff) !== 1'b1 && k < 300) begin
                    cyc(1);
                    k++;
                end
                chk(k < 300, 1'b1);
            end
        end
        chk(diff_bad, 1'b0);
        // receiver: refused while disabled, then preset clamping
        sync_gen_enable = 1'b0;
        sync_in = 1'b1;
        cyc(1);
        chk(sync_pulse_ff, 1'b0);
        sync_in = 1'b0;
        sync_rx_enable = 1'b1;
        for (i = 0; i < 5; i++) begin
            sync_preset = pv[i];
            cyc(3);
            sync_in = 1'b1;
            cyc(1);
            chk(sync_pulse_ff, 1'b1);
            cyc(1);
            chk(sync_pulse_ff, 1'b0);
            chk({common_cnt_ff, sync_clk_ff}, 5'h00);
            chk(r_cnt_ff, ex[i]);
            sync_in = 1'b0;
        end
        stop_test();
    end
endmodule // multichip_clock_sync_generator_tb
